//--- design/watchdog_nmi_pkg.sv
// Constants shared by the watchdog timer and its submodules.
package watchdog_nmi_pkg;

  // Clock and prescaler timing.
  localparam int unsigned CLK_PERIOD_NS  = 100;
  localparam int unsigned TICK_PERIOD_NS = 3906250;  // One 256 Hz period.
  localparam int unsigned TICK_CYCLES    = TICK_PERIOD_NS / CLK_PERIOD_NS;
  localparam int unsigned PRESCALE_W     = 16;

  // Watchdog counter geometry.
  localparam int unsigned      COUNT_W   = 10;
  localparam logic [COUNT_W-1:0] COUNT_MAX = 10'h3FF;

  // Bus geometry; register index is the word address adr[17:2].
  localparam int unsigned ADR_W   = 18;
  localparam int unsigned INDEX_W = 16;

  // Register indices; byte address is four times the index.
  localparam logic [INDEX_W-1:0] CTRL_INDEX   = 16'hFF07;
  localparam logic [INDEX_W-1:0] STATUS_INDEX = 16'hFF08;
  localparam logic [INDEX_W-1:0] MASK_INDEX   = 16'hFF09;

  // Control register fields.
  localparam int unsigned CLEAR_BIT    = 0;
  localparam int unsigned ENABLE_BIT   = 1;
  localparam logic        ENABLE_RESET = 1'b1;

  // Interrupt status and mask fields.
  localparam int unsigned TIMEOUT_BIT  = 0;
  localparam logic        STATUS_RESET = 1'b0;
  localparam logic        MASK_RESET   = 1'b0;

  // Handler address of the non-maskable request.
  localparam logic [11:0] NMI_VECTOR = 12'h100;

endpackage : watchdog_nmi_pkg

//--- design/tick_prescaler.sv
// Prescaler that divides the system clock down to the 256 Hz count tick.
`timescale 1ns/1ps
`default_nettype none
module tick_prescaler
  import watchdog_nmi_pkg::*;
#(
  parameter logic [PRESCALE_W-1:0] DIV = PRESCALE_W'(TICK_CYCLES)
) (
  input  wire logic clk_i,
  input  wire logic rst_b_i,
  input  wire logic enable_i,
  input  wire logic clear_i,
  output var  logic tick_o
);

  logic [PRESCALE_W-1:0] phase;
  wire                   last_phase = (phase == DIV - PRESCALE_W'(1));

  // Phase runs only while enabled; a clear restarts a full tick period so
  // that the timeout after a clear is never shortened by a stale phase.
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      phase  <= '0;
      tick_o <= 1'b0;
    end else if (clear_i) begin
      phase  <= '0;
      tick_o <= 1'b0;
    end else begin
      tick_o <= enable_i && last_phase;
      if (enable_i) begin
        phase <= last_phase ? '0 : phase + PRESCALE_W'(1);
      end
    end
  end

endmodule : tick_prescaler
`default_nettype wire

//--- design/wdt_counter.sv
// Ten-bit watchdog counter with a one-cycle overflow pulse.
`timescale 1ns/1ps
`default_nettype none
module wdt_counter
  import watchdog_nmi_pkg::*;
(
  input  wire logic               clk_i,
  input  wire logic               rst_b_i,
  input  wire logic               tick_i,
  input  wire logic               enable_i,
  input  wire logic               clear_i,
  output var  logic [COUNT_W-1:0] count_o,
  output var  logic               overflow_o
);

  wire step = tick_i && enable_i && !clear_i;

  // Counter wraps to zero on overflow and keeps going; clear has priority.
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      count_o    <= '0;
      overflow_o <= 1'b0;
    end else begin
      overflow_o <= step && (count_o == COUNT_MAX);
      if (clear_i) begin
        count_o <= '0;
      end else if (step) begin
        count_o <= count_o + COUNT_W'(1);
      end
    end
  end

endmodule : wdt_counter
`default_nettype wire

//--- design/watchdog_nmi_timer.sv
// Watchdog timer raising a non-maskable request, with a Wishbone slave.
`timescale 1ns/1ps
`default_nettype none
module watchdog_nmi_timer
  import watchdog_nmi_pkg::*;
#(
  parameter logic [PRESCALE_W-1:0] TICK_DIV = PRESCALE_W'(TICK_CYCLES)
) (
  input  wire logic               clk_i,
  input  wire logic               rst_b_i,
  input  wire logic               wb_cyc_i,
  input  wire logic               wb_stb_i,
  input  wire logic               wb_we_i,
  input  wire logic [ADR_W-1:0]   wb_adr_i,
  input  wire logic [3:0]         wb_sel_i,
  input  wire logic [31:0]        wb_dat_i,
  output var  logic [31:0]        wb_dat_o,
  output var  logic               wb_ack_o,
  output var  logic               nmi_req_o,
  output var  logic [11:0]        nmi_vector_o,
  output var  logic               irq_o
);

  // Control and interrupt state.
  logic               count_enable_bit;
  logic               timeout_status;
  logic               timeout_mask;
  logic               tick;
  logic [COUNT_W-1:0] count;

  // Bus decode. A write lands at the edge where the master sees ack high,
  // so all write strobes are qualified by the registered acknowledge.
  wire [INDEX_W-1:0] word_index = wb_adr_i[ADR_W-1:2];
  wire bus_req   = wb_cyc_i && wb_stb_i;
  wire hit_ctrl  = (word_index == CTRL_INDEX);
  wire hit_stat  = (word_index == STATUS_INDEX);
  wire hit_mask  = (word_index == MASK_INDEX);
  wire bus_write = bus_req && wb_we_i && wb_ack_o && wb_sel_i[0];
  wire wr_ctrl   = bus_write && hit_ctrl;
  wire wr_stat   = bus_write && hit_stat;
  wire wr_mask   = bus_write && hit_mask;

  // Only a one in D0 clears; a zero there leaves the count and the tick phase alone.
  wire clear_now = wr_ctrl && wb_dat_i[CLEAR_BIT];

  // Read mux; clear bit and D3..D2 are never stored and read as zero.
  wire [31:0] ctrl_view = {30'h0, count_enable_bit, 1'b0};
  wire [31:0] stat_view = {31'h0, timeout_status};
  wire [31:0] mask_view = {31'h0, timeout_mask};
  wire [31:0] read_mux;
  assign read_mux = hit_ctrl ? ctrl_view :
                    hit_stat ? stat_view :
                    hit_mask ? mask_view : 32'h0;

  // Sticky timeout flag: a new event in the clearing cycle wins.
  wire next_timeout_status =
    (timeout_status && !(wr_stat && wb_dat_i[TIMEOUT_BIT])) || nmi_req_o;

  // Acknowledge one cycle after the request; unmapped reads return zero.
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0;
    end else begin
      wb_ack_o <= bus_req && !wb_ack_o;
      if (bus_req && !wb_ack_o) begin
        wb_dat_o <= read_mux;
      end
    end
  end

  // Enable comes up set so the watchdog guards boot code unattended;
  // only D1 of a low-byte write is kept.
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      count_enable_bit <= ENABLE_RESET;
    end else if (wr_ctrl) begin
      count_enable_bit <= wb_dat_i[ENABLE_BIT];
    end
  end

  // Interrupt status and mask.
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      timeout_status <= STATUS_RESET;
      timeout_mask   <= MASK_RESET;
    end else begin
      timeout_status <= next_timeout_status;
      if (wr_mask) begin
        timeout_mask <= wb_dat_i[TIMEOUT_BIT];
      end
    end
  end

  // The mask only gates the level line; the NMI pulse itself is never
  // masked, since the core must see it whatever its interrupt state.
  assign irq_o = timeout_status && timeout_mask;

  // Vector is a fixed value held in a flip-flop after reset.
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      nmi_vector_o <= NMI_VECTOR;
    end else begin
      nmi_vector_o <= NMI_VECTOR;
    end
  end

  // The prescaler has no halt input at all: the watchdog keeps running
  // while the core sleeps, and its request is what wakes the core.
  tick_prescaler #(
    .DIV      (TICK_DIV)
  ) u_prescaler (
    .clk_i    (clk_i),
    .rst_b_i  (rst_b_i),
    .enable_i (count_enable_bit),
    .clear_i  (clear_now),
    .tick_o   (tick)
  );

  // Overflow of the last stage drives the non-maskable request directly.
  wdt_counter u_counter (
    .clk_i      (clk_i),
    .rst_b_i    (rst_b_i),
    .tick_i     (tick),
    .enable_i   (count_enable_bit),
    .clear_i    (clear_now),
    .count_o    (count),
    .overflow_o (nmi_req_o)
  );

  // ---------------------------------------------------------------------
  // Checks on the behaviour above.

  sequence ctrl_write_s;
    wr_ctrl;
  endsequence

  sequence ctrl_read_s;
    bus_req && !wb_we_i && hit_ctrl && !wb_ack_o;
  endsequence

  sequence last_step_s;
    tick && count_enable_bit && !clear_now && (count == COUNT_MAX);
  endsequence

  enable_write_a: assert property (
    @(posedge clk_i) disable iff (!rst_b_i)
    ctrl_write_s |=> (count_enable_bit == $past(wb_dat_i[ENABLE_BIT])))
    else $error("Enable bit did not take the written value.");

  disabled_hold_a: assert property (
    @(posedge clk_i) disable iff (!rst_b_i)
    (!count_enable_bit && !clear_now) |=> ($stable(count) && !nmi_req_o))
    else $error("Counter moved or request rose while disabled.");

  clear_write_a: assert property (
    @(posedge clk_i) disable iff (!rst_b_i)
    (ctrl_write_s ##0 wb_dat_i[CLEAR_BIT]) |=> (count == '0) && !nmi_req_o)
    else $error("Counter not cleared by a clear write.");

  zero_write_a: assert property (
    @(posedge clk_i) disable iff (!rst_b_i)
    (ctrl_write_s ##0 !wb_dat_i[CLEAR_BIT] ##0 count != COUNT_MAX)
    |=> (count == $past(count)) || (count == $past(count) + COUNT_W'(1)))
    else $error("Writing zero to the clear bit disturbed the counter.");

  ctrl_readback_a: assert property (
    @(posedge clk_i) disable iff (!rst_b_i)
    ctrl_read_s |=> wb_ack_o && (wb_dat_o[31:2] == 30'h0)
                    && !wb_dat_o[CLEAR_BIT]
                    && (wb_dat_o[ENABLE_BIT] == $past(count_enable_bit)))
    else $error("Control readback has wrong bits.");

  overflow_req_a: assert property (
    @(posedge clk_i) disable iff (!rst_b_i)
    last_step_s |=> nmi_req_o && (count == '0))
    else $error("Overflow did not raise the request and wrap.");

  req_cause_a: assert property (
    @(posedge clk_i) disable iff (!rst_b_i)
    nmi_req_o |-> $past(count) == COUNT_MAX && count == '0)
    else $error("Request without an overflow of the counter.");

  req_pulse_a: assert property (
    @(posedge clk_i) disable iff (!rst_b_i)
    nmi_req_o |=> !nmi_req_o ##1 !nmi_req_o)
    else $error("Request lasted longer than one cycle.");

  req_sticky_a: assert property (
    @(posedge clk_i) disable iff (!rst_b_i)
    nmi_req_o |=> timeout_status
                  ##1 (timeout_status
                       || $past(wr_stat && wb_dat_i[TIMEOUT_BIT])))
    else $error("Timeout status did not latch the request.");

  vector_value_a: assert property (
    @(posedge clk_i) disable iff (!rst_b_i)
    nmi_req_o |-> nmi_vector_o == 12'h100)
    else $error("Request vector is not 0100H.");

  ack_once_a: assert property (
    @(posedge clk_i) disable iff (!rst_b_i)
    wb_ack_o |=> !wb_ack_o)
    else $error("Acknowledge held for more than one cycle.");

  // Further checks on the bus, the small interrupt registers and the tick.
  // The readback checks guard against a mux that swaps the status and mask
  // words, which the control readback alone would never notice.

  sequence stat_read_s;
    bus_req && !wb_we_i && hit_stat && !wb_ack_o;
  endsequence

  sequence mask_read_s;
    bus_req && !wb_we_i && hit_mask && !wb_ack_o;
  endsequence

  sequence stray_read_s;
    bus_req && !wb_we_i && !wb_ack_o && !hit_ctrl && !hit_stat && !hit_mask;
  endsequence

  sequence status_clear_s;
    wr_stat && wb_dat_i[TIMEOUT_BIT] && !nmi_req_o;
  endsequence

  ack_timing_a: assert property (
    @(posedge clk_i) disable iff (!rst_b_i)
    (bus_req && !wb_ack_o) |=> wb_ack_o)
    else $error("Acknowledge did not follow the request.");

  ack_cause_a: assert property (
    @(posedge clk_i) disable iff (!rst_b_i)
    wb_ack_o |-> $past(bus_req && !wb_ack_o))
    else $error("Acknowledge without a request.");

  status_read_a: assert property (
    @(posedge clk_i) disable iff (!rst_b_i)
    stat_read_s |=> wb_dat_o == {31'h0, $past(timeout_status)})
    else $error("Status readback has wrong bits.");

  mask_read_a: assert property (
    @(posedge clk_i) disable iff (!rst_b_i)
    mask_read_s |=> wb_dat_o == {31'h0, $past(timeout_mask)})
    else $error("Mask readback has wrong bits.");

  stray_read_a: assert property (
    @(posedge clk_i) disable iff (!rst_b_i)
    stray_read_s |=> wb_dat_o == 32'h0)
    else $error("Unmapped read returned nonzero data.");

  status_clear_a: assert property (
    @(posedge clk_i) disable iff (!rst_b_i)
    status_clear_s |=> !timeout_status)
    else $error("Writing one did not clear the timeout status.");

  status_hold_a: assert property (
    @(posedge clk_i) disable iff (!rst_b_i)
    (timeout_status && !(wr_stat && wb_dat_i[TIMEOUT_BIT]))
    |=> timeout_status)
    else $error("Timeout status dropped without a clear.");

  mask_write_a: assert property (
    @(posedge clk_i) disable iff (!rst_b_i)
    wr_mask |=> timeout_mask == $past(wb_dat_i[TIMEOUT_BIT]))
    else $error("Mask did not take the written value.");

  tick_disabled_a: assert property (
    @(posedge clk_i) disable iff (!rst_b_i)
    !count_enable_bit |=> !tick)
    else $error("Count tick while the watchdog is disabled.");

  tick_single_a: assert property (
    @(posedge clk_i) disable iff (!rst_b_i)
    tick |=> !tick)
    else $error("Count tick lasted more than one cycle.");

  count_step_a: assert property (
    @(posedge clk_i) disable iff (!rst_b_i)
    (tick && count_enable_bit && !clear_now && (count != COUNT_MAX))
    |=> count == $past(count) + COUNT_W'(1))
    else $error("Counter did not advance on a tick.");

  clear_restart_a: assert property (
    @(posedge clk_i) disable iff (!rst_b_i)
    clear_now |=> !tick && (count == '0))
    else $error("Clear did not restart the count and the tick.");

endmodule : watchdog_nmi_timer
`default_nettype wire

//--- tb/cpu_core_model.sv
// Behavioural core that takes the watchdog request.
`timescale 1ns/1ps
`default_nettype none
module cpu_core_model (
  input  wire logic        clk_i,
  input  wire logic        rst_b_i,
  input  wire logic        halt_i,
  input  wire logic        nmi_req_i,
  input  wire logic [11:0] vector_i,
  output var  logic        halted_o,
  output var  logic [7:0]  taken_o,
  output var  logic [11:0] pc_o
);
  // The request has no mask, so it is taken even while halted.
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      halted_o <= 1'b0;
      taken_o  <= 8'h00;
      pc_o     <= 12'h000;
    end else if (nmi_req_i) begin
      halted_o <= 1'b0;
      taken_o  <= taken_o + 8'h01;
      pc_o     <= vector_i;
    end else if (halt_i) begin
      halted_o <= 1'b1;
    end
  end
endmodule : cpu_core_model
`default_nettype wire

//--- tb/tb_top.sv
// Self-checking bench for the watchdog timer.
`timescale 1ns/1ps
`default_nettype none
module tb_top
  import watchdog_nmi_pkg::*;
;
  logic        clk_i = 1'b0;
  logic        rst_b_i = 1'b0;
  logic        cyc = 1'b0, stb = 1'b0, we = 1'b0, halt = 1'b0;
  logic [17:0] adr = 18'h00000;
  logic [31:0] dat = 32'h00000000;
  logic [31:0] rdat;
  logic        ack, nmi, irq, halted;
  logic [11:0] vec, pc;
  logic [7:0]  taken;
  logic [31:0] exp_q[$];
  int          fail_count = 0, checked = 0, seed = 58, n;
  time         t0;
  localparam logic [17:0] CTRL = {CTRL_INDEX, 2'b00};
  localparam logic [17:0] STAT = {STATUS_INDEX, 2'b00};
  localparam logic [17:0] MASK = {MASK_INDEX, 2'b00};

  // A short prescaler keeps one timeout at 4096 cycles.
  always #50 clk_i = ~clk_i;
  watchdog_nmi_timer #(.TICK_DIV(16'h0004)) dut_u (.clk_i(clk_i),
    .rst_b_i(rst_b_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(4'h1), .wb_dat_i(dat), .wb_dat_o(rdat),
    .wb_ack_o(ack), .nmi_req_o(nmi), .nmi_vector_o(vec), .irq_o(irq));
  cpu_core_model core_u (.clk_i(clk_i), .rst_b_i(rst_b_i), .halt_i(halt),
    .nmi_req_i(nmi), .vector_i(vec), .halted_o(halted), .taken_o(taken),
    .pc_o(pc));

  task automatic chk(input logic ok, input string msg);
    checked++;
    if (ok !== 1'b1) begin
      fail_count++;
      $display("mismatch at %0t: %s", $time, msg);
    end
  endtask : chk

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : print_verdict

  // Classic single cycle; the request is held until ack is sampled.
  task automatic wb(input logic w, input logic [17:0] a,
                    input logic [31:0] d);
    int k;
    k = 0;
    cyc <= 1'b1;
    stb <= 1'b1;
    we  <= w;
    adr <= a;
    dat <= d;
    do begin
      @(posedge clk_i);
      k++;
    end while (ack !== 1'b1 && k < 20);
    if (k >= 20) chk(1'b0, "no acknowledge");
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk_i);
  endtask : wb

  task automatic rd(input logic [17:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    wb(1'b0, a, 32'h00000000);
  endtask : rd

  // Samples at the falling edge, where the registered request is settled.
  task automatic wait_nmi(input int lim, input bit want);
    n = 0;
    while (nmi !== 1'b1 && n < lim) begin
      @(negedge clk_i);
      n++;
    end
    if (want && nmi !== 1'b1) chk(1'b0, "no request in time");
  endtask : wait_nmi

  // Read data is compared in order against the driver's notes.
  always @(posedge clk_i) begin
    if (ack === 1'b1 && we === 1'b0) begin
      chk(exp_q.size() > 0 && rdat === exp_q[0], "read data");
      if (exp_q.size() > 0) void'(exp_q.pop_front());
    end
  end

  // A hang ends the run through the same verdict.
  initial begin
    #4000000;
    chk(1'b0, "run limit");
    print_verdict();
  end

  initial begin
    repeat (6) @(posedge clk_i);
    rst_b_i <= 1'b1;
    @(posedge clk_i);
    rd(CTRL, 32'h00000002);
    rd(MASK, 32'h00000000);
    wb(1'b1, 18'h00010, 32'hFFFFFFFF);
    rd(18'h00010, 32'h00000000);
    $display("test reset done");
    wb(1'b1, CTRL, 32'h0000000D);
    rd(CTRL, 32'h00000000);
    wait_nmi(6000, 1'b0);
    chk(n >= 6000 && taken === 8'h00, "request while off");
    $display("test disable done");
    wb(1'b1, CTRL, 32'h00000003);
    t0 = $time;
    rd(CTRL, 32'h00000002);
    repeat (1500) @(posedge clk_i);
    wb(1'b1, CTRL, ({$random(seed)} & 32'hFFFFFFFE) | 32'h2);
    rd(CTRL, 32'h00000002);
    wb(1'b1, MASK, 32'h00000001);
    halt <= 1'b1;
    @(posedge clk_i);
    halt <= 1'b0;
    @(negedge clk_i);
    chk(halted === 1'b1 && taken === 8'h00, "halt entered");
    wait_nmi(4000, 1'b1);
    n = int'(($time - t0) / 100);
    chk(n > 4085 && n < 4105 && vec === 12'h100, "first timeout");
    t0 = $time;
    @(negedge clk_i);
    chk(nmi === 1'b0 && irq === 1'b1, "pulse or irq");
    chk(halted === 1'b0 && pc === 12'h100, "wake");
    @(posedge clk_i);
    rd(STAT, 32'h00000001);
    wb(1'b1, MASK, 32'h00000000);
    chk(irq === 1'b0, "masked irq");
    wb(1'b1, STAT, 32'h00000001);
    rd(STAT, 32'h00000000);
    wait_nmi(4200, 1'b1);
    chk($time - t0 == 409600, "wrap period");
    $display("test timeout done");
    repeat (3) begin
      repeat (3000) @(posedge clk_i);
      wb(1'b1, CTRL, 32'h00000003);
    end
    chk(taken === 8'h02 && exp_q.size() == 0, "serviced");
    $display("test service done");
    wb(1'b1, CTRL, 32'h00000000);
    rst_b_i <= 1'b0;
    repeat (6) @(posedge clk_i);
    rst_b_i <= 1'b1;
    @(posedge clk_i);
    rd(CTRL, 32'h00000002);
    chk(taken === 8'h00 && irq === 1'b0, "reset state");
    $display("test second reset done");
    print_verdict();
  end
endmodule : tb_top
`default_nettype wire
